// >>> logic/codec_port_serdes.sv
// Per-port codec serialiser: two received bytes in, one chosen serial
// stream out; serial samples in, one parallel byte out per frame.
// Assumes frameTick and bitTick are single-cycle strobes on clk.
`timescale 1ns/1ps
module codec_port_serdes (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       frameTick,
  input  wire logic       bitTick,
  input  wire logic       busSel,
  input  wire logic [7:0] rxA,
  input  wire logic [7:0] rxB,
  input  wire logic       codecIn,
  output logic            codecOut,
  output logic      [7:0] txByte
);

  typedef struct packed {
    logic [7:0] shOut;
    logic [7:0] shIn;
    logic [7:0] txByte;
    logic [3:0] cnt;
    logic       out;
  } serdes_t;

  serdes_t r_r;
  serdes_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (frameTick) begin
      r_nxt.shOut  = busSel ? rxB : rxA;
      r_nxt.txByte = r_r.shIn;
      r_nxt.cnt    = pcm_port_pkg::SAMPLE_BITS;
    end else if (bitTick && r_r.cnt != 4'h0) begin
      r_nxt.out   = r_r.shOut[7];
      r_nxt.shOut = {r_r.shOut[6:0], 1'b0};
      r_nxt.shIn  = {r_r.shIn[6:0], codecIn};
      r_nxt.cnt   = r_r.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign codecOut = r_r.out;
  assign txByte   = r_r.txByte;

endmodule

// >>> logic/pcm_port_pkg.sv
// Shared constants for the eight-port PCM time slot line card logic.
// Assumes a 25 MHz system clock and an 8-bit register port.
package pcm_port_pkg;

  // ---------------------------------------------------------------
  // Clocking
  // ---------------------------------------------------------------
  localparam int CLK_HZ     = 25_000_000;
  localparam int RATE_LO_HZ = 1_544_000;
  localparam int RATE_HI_HZ = 2_048_000;
  // Half periods of the codec clock, rounded down so the rate is never below target.
  localparam logic [4:0] HALF_LO = 5'(CLK_HZ / (2 * RATE_LO_HZ));
  localparam logic [4:0] HALF_HI = 5'(CLK_HZ / (2 * RATE_HI_HZ));

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int         NPORT     = 8;
  localparam logic [7:0] NPORT_W   = 8'h08;
  localparam logic [3:0] SAMPLE_BITS = 4'h8;
  localparam int         SYNC_W    = 74;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] CTRL_OFS     = 5'h00;
  localparam logic [4:0] BASE_OFS     = 5'h01;
  localparam logic [4:0] TXBUS_OFS    = 5'h02;
  localparam logic [4:0] RELAY_OFS    = 5'h03;
  localparam logic [4:0] HOOK_OFS     = 5'h04;
  localparam logic [4:0] HOOKEVT_OFS  = 5'h05;
  localparam logic [4:0] TONEEVT_OFS  = 5'h06;
  localparam logic [4:0] LAMP_OFS     = 5'h07;
  localparam logic [4:0] LISTEN_OFS   = 5'h08;
  localparam logic [4:0] BUSREQ_OFS   = 5'h10;
  localparam logic [4:0] BUSACT_OFS   = 5'h11;
  localparam logic [4:0] DIGIT_OFS    = 5'h18;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int         CTRL_RATE_BIT = 0;
  localparam int         CTRL_LAW_BIT  = 1;
  localparam logic [1:0] CTRL_RST      = 2'h2;
  localparam logic [7:0] BASE_RST      = 8'h00;

  // True when a slot lies in the eight-slot block starting at base.
  function automatic logic inWindow(input logic [7:0] slot, input logic [7:0] base);
    logic [7:0] d;
    d = slot - base;
    return d < NPORT_W;
  endfunction

endpackage

// >>> logic/pcm_timeslot_port.sv
// Digital side of an eight-port analogue line card: PCM time slot bus
// transmit and receive, codec serial links, hook and relay control,
// tone digit event collection and the controller register port.
// Assumes the slot strobe, frame marker, bus data and all line-side
// signals are asynchronous to clk and slow compared with it.
//
// How it works
// - card owns eight consecutive slot addresses.
// - drive bus only in own eight slots.
// - each port listens to any slot, either bus.
// - both PCM buses handled identically.
// - listen target named by slot and bus.
// - selected byte latched per bus per port.
// - bus select picks which register feeds codec.
// - codec serial converted to and from bytes.
// - codec clock 1.544 or 2.048 MHz, card-wide.
// - A-law or mu-law, one card-wide setting.
// - per-port hook status bit is readable.
// - reversal relay energised only by command.
// - relay forced off while port off hook.
// - sixteen tone digits recognised per port.
// - tone receivers run on separate oscillator.
// - controller polls eight ports for events.
// - changes reported only when controller polls.
// - register drives red, yellow, green lamps.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module pcm_timeslot_port (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  output logic      [7:0]  rdData,
  input  wire logic        frameIn,
  input  wire logic        slotIn,
  input  wire logic [7:0]  busAIn,
  input  wire logic [7:0]  busBIn,
  output logic      [7:0]  busAOut,
  output logic             busAOe,
  output logic      [7:0]  busBOut,
  output logic             busBOe,
  input  wire logic [7:0]  hookIn,
  input  wire logic [7:0]  toneValid,
  input  wire logic [31:0] toneCode,
  input  wire logic [7:0]  codecIn,
  output logic             codecClk,
  output logic             codecSync,
  output logic      [7:0]  codecOut,
  output logic             lawSel,
  output logic             rateSel,
  output logic      [7:0]  relayDrive,
  output logic      [2:0]  lamps
);

  // ---------------------------------------------------------------
  // Limitations
  // ---------------------------------------------------------------
  // The codec clock is made from whole clk cycles per half period, so
  // both rates run slightly fast; codecs that need exact rates want a PLL.
  // The relay register keeps its command while a line is off hook, so
  // the relay comes back by itself once the line returns on hook.
  // Slot and frame pins pass the synchroniser, which costs about four
  // clocks of latency; a slot must last well beyond that.

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]      ctrl;
    logic [7:0]      baseSlot;
    logic            txBus;
    logic [7:0]      relay;
    logic [7:0]      relayOut;
    logic [2:0]      lamps;
    logic [7:0][7:0] listenSlot;
    logic [7:0][7:0] rxA;
    logic [7:0][7:0] rxB;
    logic [7:0]      busReq;
    logic [7:0]      busAct;
    logic [7:0]      hookSeen;
    logic [7:0]      toneSeen;
    logic [7:0]      hookEvt;
    logic [7:0]      toneEvt;
    logic [7:0][3:0] digit;
    logic [2:0]      scanIdx;
    logic [7:0]      slot;
    logic [7:0]      rdData;
    logic [7:0]      busAOut;
    logic [7:0]      busBOut;
    logic            busAOe;
    logic            busBOe;
    logic            slotSeen;
    logic            codecClk;
    logic            codecSync;
    logic [4:0]      divCnt;
  } state_t;

  state_t q_r;
  state_t q_nxt;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // The listen and digit banks each hold eight consecutive indices, so
  // only the upper two address bits pick the bank.
  function automatic logic inBank(input logic [4:0] a, input logic [4:0] bankBase);
    return a[4:3] == bankBase[4:3];
  endfunction

  // Writes and reads both need the listen bank test.
  function automatic logic isListen(input logic [4:0] a);
    return inBank(a, pcm_port_pkg::LISTEN_OFS);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  logic [pcm_port_pkg::SYNC_W-1:0] syn;
  logic                            fS;
  logic                            sS;
  logic [7:0]                      bA;
  logic [7:0]                      bB;
  logic [7:0]                      hookS;
  logic [7:0]                      toneS;
  logic [31:0]                     codeS;
  logic [7:0]                      cdIn;

  // Tone receivers run on their own oscillator, so their outputs are
  // treated like any other asynchronous pin.
  pin_sync #(
    .W (pcm_port_pkg::SYNC_W)
  ) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({frameIn, slotIn, busAIn, busBIn, hookIn, toneValid, toneCode, codecIn}),
    .q     (syn)
  );

  assign {fS, sS, bA, bB, hookS, toneS, codeS, cdIn} = syn;

  // ---------------------------------------------------------------
  // Timing strobes
  // ---------------------------------------------------------------
  logic slotEdge;
  logic frameTick;
  logic bitTick;

  assign slotEdge  = sS & ~q_r.slotSeen;
  // The frame marker is sampled at the slot strobe that opens slot zero.
  assign frameTick = slotEdge & fS;
  assign bitTick   = (q_r.divCnt == 5'h00) & ~q_r.codecClk;

  // ---------------------------------------------------------------
  // Per-port codec serialisers
  // ---------------------------------------------------------------
  logic [7:0][7:0] txByte;

  for (genvar p = 0; p < pcm_port_pkg::NPORT; p++) begin : gPort
    codec_port_serdes uSerdes (
      .clk       (clk),
      .rst_n     (rst_n),
      .frameTick (frameTick),
      .bitTick   (bitTick),
      .busSel    (q_r.busAct[p]),
      .rxA       (q_r.rxA[p]),
      .rxB       (q_r.rxB[p]),
      .codecIn   (cdIn[p]),
      .codecOut  (codecOut[p]),
      .txByte    (txByte[p])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] nSlot;
    logic [7:0] ofs;
    logic       win;
    nSlot = q_r.slot;
    ofs   = 8'h00;
    win   = 1'b0;
    q_nxt = q_r;

    // ---------------------------------------------------------------
    // Slots
    // ---------------------------------------------------------------
    // Slot tracking, receive capture and transmit window.
    q_nxt.slotSeen = sS;
    if (slotEdge) begin
      nSlot      = fS ? 8'h00 : q_r.slot + 8'h01;
      q_nxt.slot = nSlot;
      for (int p = 0; p < pcm_port_pkg::NPORT; p++) begin
        if (nSlot == q_r.listenSlot[p]) begin
          q_nxt.rxA[p] = bA;
          q_nxt.rxB[p] = bB;
        end
      end
      win = pcm_port_pkg::inWindow(nSlot, q_r.baseSlot);
      ofs = nSlot - q_r.baseSlot;
      q_nxt.busAOe  = win & ~q_r.txBus;
      q_nxt.busBOe  = win & q_r.txBus;
      q_nxt.busAOut = (win & ~q_r.txBus) ? txByte[ofs[2:0]] : 8'h00;
      q_nxt.busBOut = (win & q_r.txBus) ? txByte[ofs[2:0]] : 8'h00;
    end

    // ---------------------------------------------------------------
    // Bus select
    // ---------------------------------------------------------------
    // A bus change mid-frame would splice two sources into one sample.
    if (frameTick) begin
      q_nxt.busAct = q_r.busReq;
    end

    // ---------------------------------------------------------------
    // Codec clock
    // ---------------------------------------------------------------
    // Codec clock divider; the rate applies to all ports at once.
    if (q_r.divCnt == 5'h00) begin
      q_nxt.codecClk = ~q_r.codecClk;
      q_nxt.divCnt   = (q_r.ctrl[pcm_port_pkg::CTRL_RATE_BIT] ? pcm_port_pkg::HALF_HI
                        : pcm_port_pkg::HALF_LO) - 5'h01;
    end else begin
      q_nxt.divCnt = q_r.divCnt - 5'h01;
    end
    // Sync covers the first bit period; a new frame wins over the end.
    if (bitTick) begin
      q_nxt.codecSync = 1'b0;
    end
    if (frameTick) begin
      q_nxt.codecSync = 1'b1;
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // Read-only and unmapped indices fall through and are ignored.
    if (wrEn) begin
      unique case (addr)
        pcm_port_pkg::CTRL_OFS:   q_nxt.ctrl     = wrData[1:0];
        pcm_port_pkg::BASE_OFS:   q_nxt.baseSlot = wrData;
        pcm_port_pkg::TXBUS_OFS:  q_nxt.txBus    = wrData[0];
        pcm_port_pkg::RELAY_OFS:  q_nxt.relay    = wrData;
        pcm_port_pkg::LAMP_OFS:   q_nxt.lamps    = wrData[2:0];
        pcm_port_pkg::BUSREQ_OFS: q_nxt.busReq   = wrData;
        default: begin
          if (isListen(addr)) begin
            q_nxt.listenSlot[addr[2:0]] = wrData;
          end
        end
      endcase
    end

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------
    // Read data stand for exactly one cycle.
    q_nxt.rdData = 8'h00;
    if (rdEn) begin
      unique case (addr)
        pcm_port_pkg::CTRL_OFS:    q_nxt.rdData = {6'h00, q_r.ctrl};
        pcm_port_pkg::BASE_OFS:    q_nxt.rdData = q_r.baseSlot;
        pcm_port_pkg::TXBUS_OFS:   q_nxt.rdData = {7'h00, q_r.txBus};
        pcm_port_pkg::RELAY_OFS:   q_nxt.rdData = q_r.relay;
        pcm_port_pkg::HOOK_OFS:    q_nxt.rdData = hookS;
        pcm_port_pkg::HOOKEVT_OFS: q_nxt.rdData = q_r.hookEvt;
        pcm_port_pkg::TONEEVT_OFS: q_nxt.rdData = q_r.toneEvt;
        pcm_port_pkg::LAMP_OFS:    q_nxt.rdData = {5'h00, q_r.lamps};
        pcm_port_pkg::BUSREQ_OFS:  q_nxt.rdData = q_r.busReq;
        pcm_port_pkg::BUSACT_OFS:  q_nxt.rdData = q_r.busAct;
        default: begin
          if (isListen(addr)) begin
            q_nxt.rdData = q_r.listenSlot[addr[2:0]];
          end else if (inBank(addr, pcm_port_pkg::DIGIT_OFS)) begin
            q_nxt.rdData = {4'h0, q_r.digit[addr[2:0]]};
          end
        end
      endcase
      // Reading an event register is the poll that reports and clears it.
      if (addr == pcm_port_pkg::HOOKEVT_OFS) begin
        q_nxt.hookEvt = 8'h00;
      end
      if (addr == pcm_port_pkg::TONEEVT_OFS) begin
        q_nxt.toneEvt = 8'h00;
      end
    end

    // ---------------------------------------------------------------
    // Event scanner
    // ---------------------------------------------------------------
    // Event scanner visits one port per cycle. Tones and gaps last
    // milliseconds, so an eight-cycle round cannot miss one. Sets come
    // after the clears so an event in the clearing cycle survives.
    q_nxt.scanIdx = q_r.scanIdx + 3'h1;
    if (hookS[q_r.scanIdx] != q_r.hookSeen[q_r.scanIdx]) begin
      q_nxt.hookSeen[q_r.scanIdx] = hookS[q_r.scanIdx];
      q_nxt.hookEvt[q_r.scanIdx]  = 1'b1;
    end
    if (toneS[q_r.scanIdx] != q_r.toneSeen[q_r.scanIdx]) begin
      q_nxt.toneSeen[q_r.scanIdx] = toneS[q_r.scanIdx];
      if (toneS[q_r.scanIdx]) begin
        q_nxt.toneEvt[q_r.scanIdx] = 1'b1;
        q_nxt.digit[q_r.scanIdx]   = codeS[4 * q_r.scanIdx +: 4];
      end
    end

    // ---------------------------------------------------------------
    // Relay
    // ---------------------------------------------------------------
    // The relay only follows a command and drops out while off hook.
    q_nxt.relayOut = q_r.relay & ~hookS;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r          <= '0;
      q_r.ctrl     <= pcm_port_pkg::CTRL_RST;
      q_r.baseSlot <= pcm_port_pkg::BASE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdData     = q_r.rdData;
  assign busAOut    = q_r.busAOut;
  assign busAOe     = q_r.busAOe;
  assign busBOut    = q_r.busBOut;
  assign busBOe     = q_r.busBOe;
  assign codecClk   = q_r.codecClk;
  assign codecSync  = q_r.codecSync;
  assign lawSel     = q_r.ctrl[pcm_port_pkg::CTRL_LAW_BIT];
  assign rateSel    = q_r.ctrl[pcm_port_pkg::CTRL_RATE_BIT];
  assign relayDrive = q_r.relayOut;
  assign lamps      = q_r.lamps;

endmodule

// >>> logic/pin_sync.sv
// Three-stage synchroniser for a bundle of pin inputs.
// Assumes inputs change slowly relative to clk; an output only moves
// once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } sync_t;

  sync_t r_r;
  sync_t r_nxt;

  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.o[i] = r_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.o;

endmodule

// >>> tb/pcm_backplane_model.sv
// Backplane model: slot strobes, frame marker and data of both PCM buses.
// Assumes run rises once the card is configured; 16 slots of 12 clocks a frame.
`timescale 1ns/1ps
module pcm_backplane_model (
  input  wire logic       clk,
  input  wire logic       run,
  output logic            frameIn,
  output logic            slotIn,
  output logic      [7:0] busAIn,
  output logic      [7:0] busBIn,
  output logic      [7:0] curSlot
);
  logic [3:0] cyc = 4'h0;
  logic [7:0] nxt;
  initial begin
    curSlot = 8'h0f;
    slotIn = 1'b0;
    frameIn = 1'b0;
    busAIn = 8'h00;
    busBIn = 8'hff;
  end
  // Data change with the strobe so both pass the card's synchroniser together.
  always @(posedge clk) begin
    cyc <= (cyc == 4'd11) ? 4'h0 : cyc + 4'h1;
    nxt = (curSlot == 8'h0f) ? 8'h00 : curSlot + 8'h01;
    if (!run) begin
      busAIn <= busAIn + 8'h01;
      busBIn <= ~busAIn;
    end else if (cyc == 4'd11) begin
      curSlot <= nxt;
      slotIn <= 1'b1;
      frameIn <= (nxt == 8'h00);
      busAIn <= nxt ^ 8'h3c;
      busBIn <= nxt ^ 8'hc3;
    end else if (cyc == 4'd5) begin
      slotIn <= 1'b0;
      frameIn <= 1'b0;
    end
  end
endmodule

// >>> tb/pcm_timeslot_port_sva.sv
// Checker for the PCM time slot port: bus drive, codec clock, relay and read port.
// Assumes the bench backplane gives every slot 12 clocks.
`timescale 1ns/1ps
module pcm_timeslot_port_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       rdEn,
  input wire logic [7:0] rdData,
  input wire logic [7:0] busAOut,
  input wire logic       busAOe,
  input wire logic [7:0] busBOut,
  input wire logic       busBOe,
  input wire logic [7:0] hookIn,
  input wire logic       codecClk,
  input wire logic       codecSync,
  input wire logic       rateSel,
  input wire logic [7:0] relayDrive
);
  // ---------------------------------------------------------------
  // Drive length counter
  // ---------------------------------------------------------------
  localparam int SLOT_CYC = 12;
  logic [7:0] oeCnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oeCnt_r <= 8'h00;
    else oeCnt_r <= (busAOe | busBOe) ? oeCnt_r + 8'h01 : 8'h00;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_hiRate;
    rateSel ##1 (rateSel && $rose(codecClk)) ##1 rateSel [*6];
  endsequence
  sequence s_loRate;
    !rateSel ##1 (!rateSel && $rose(codecClk)) ##1 !rateSel [*8];
  endsequence

  property p_oneBus; !(busAOe && busBOe); endproperty
  property p_aIdle; !busAOe |-> busAOut == 8'h00; endproperty
  property p_bIdle; !busBOe |-> busBOut == 8'h00; endproperty
  property p_oeLen; $fell(busAOe | busBOe) |-> oeCnt_r == 8'(8 * SLOT_CYC); endproperty
  property p_relayOff; $stable(hookIn) [*8] |-> (relayDrive & hookIn) == 8'h00; endproperty
  property p_rdIdle; !rdEn |=> rdData == 8'h00; endproperty
  property p_halfHi; s_hiRate |-> !codecClk && $past(codecClk); endproperty
  property p_halfLo; s_loRate |-> !codecClk && $past(codecClk); endproperty
  property p_syncLen; $rose(codecSync) |-> ##[1:20] !codecSync; endproperty

  a_oneBus: assert property (p_oneBus) else $error("both buses driven");
  a_aIdle: assert property (p_aIdle) else $error("bus A data while idle");
  a_bIdle: assert property (p_bIdle) else $error("bus B data while idle");
  a_oeLen: assert property (p_oeLen) else $error("drive not eight slots");
  a_relayOff: assert property (p_relayOff) else $error("relay on off hook");
  a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
  a_halfHi: assert property (p_halfHi) else $error("fast codec half wrong");
  a_halfLo: assert property (p_halfLo) else $error("slow codec half wrong");
  a_syncLen: assert property (p_syncLen) else $error("codec sync too long");
endmodule

bind pcm_timeslot_port pcm_timeslot_port_sva i_sva (.clk(clk), .rst_n(rst_n), .rdEn(rdEn),
  .rdData(rdData), .busAOut(busAOut), .busAOe(busAOe), .busBOut(busBOut), .busBOe(busBOe),
  .hookIn(hookIn), .codecClk(codecClk), .codecSync(codecSync), .rateSel(rateSel),
  .relayDrive(relayDrive));

// >>> tb/testbench.sv
// Self-checking bench for the PCM time slot port.
// Assumes the backplane model above and constant codec serial inputs.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wrData = 8'h00;
  logic        wrEn = 1'b0;
  logic        rdEn = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  hookIn = 8'h00;
  logic [7:0]  toneValid = 8'h00;
  logic [31:0] toneCode = 32'h0;
  logic [7:0]  codecIn = 8'h0f;
  logic [7:0]  rdData, busAIn, busBIn, busAOut, busBOut, curSlot, codecOut, relayDrive;
  logic        frameIn, slotIn, busAOe, busBOe, codecClk, codecSync, lawSel, rateSel;
  logic [2:0]  lamps;
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #20 clk = ~clk;

  pcm_backplane_model i_bp (.clk(clk), .run(run), .frameIn(frameIn), .slotIn(slotIn),
    .busAIn(busAIn), .busBIn(busBIn), .curSlot(curSlot));
  pcm_timeslot_port i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .frameIn(frameIn), .slotIn(slotIn),
    .busAIn(busAIn), .busBIn(busBIn), .busAOut(busAOut), .busAOe(busAOe),
    .busBOut(busBOut), .busBOe(busBOe), .hookIn(hookIn), .toneValid(toneValid),
    .toneCode(toneCode), .codecIn(codecIn), .codecClk(codecClk), .codecSync(codecSync),
    .codecOut(codecOut), .lawSel(lawSel), .rateSel(rateSel), .relayDrive(relayDrive),
    .lamps(lamps));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk(rdData, exp);
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_ctrl();
    chk({6'h00, lawSel, rateSel}, 8'h02);
    rdChk(pcm_port_pkg::CTRL_OFS, 8'(pcm_port_pkg::CTRL_RST));
    wr(pcm_port_pkg::CTRL_OFS, 8'h01);
    idle(60);
    chk({6'h00, lawSel, rateSel}, 8'h01);
    wr(pcm_port_pkg::CTRL_OFS, 8'h02);
    idle(60);
    chk({6'h00, lawSel, rateSel}, 8'h02);
    wr(pcm_port_pkg::LAMP_OFS, 8'h05);
    idle(2);
    chk({5'h00, lamps}, 8'h05);
    rdChk(pcm_port_pkg::LAMP_OFS, 8'h05);
    rdChk(5'h12, 8'h00);
  endtask
  task automatic t_hook();
    wr(pcm_port_pkg::RELAY_OFS, 8'hff);
    idle(2);
    chk(relayDrive, 8'hff);
    @(posedge clk) hookIn <= 8'h0f;
    idle(20);
    chk(relayDrive, 8'hf0);
    wr(pcm_port_pkg::HOOK_OFS, 8'hff);
    rdChk(pcm_port_pkg::HOOK_OFS, 8'h0f);
    rdChk(pcm_port_pkg::HOOKEVT_OFS, 8'h0f);
    rdChk(pcm_port_pkg::HOOKEVT_OFS, 8'h00);
    @(posedge clk) hookIn <= 8'h00;
    idle(20);
    chk(relayDrive, 8'hff);
    rdChk(pcm_port_pkg::HOOKEVT_OFS, 8'h0f);
    wr(pcm_port_pkg::RELAY_OFS, 8'h00);
  endtask
  task automatic t_tone();
    logic [31:0] code;
    for (int ps = 0; ps < 2; ps++) begin
      for (int p = 0; p < 8; p++) code[4*p +: 4] = 4'(ps * 8 + p);
      @(posedge clk) toneCode <= code;
      idle(6);
      toneValid <= 8'hff;
      idle(30);
      rdChk(pcm_port_pkg::TONEEVT_OFS, 8'hff);
      for (int p = 0; p < 8; p++) rdChk(5'(pcm_port_pkg::DIGIT_OFS + p), {4'h0, code[4*p +: 4]});
      rdChk(pcm_port_pkg::TONEEVT_OFS, 8'h00);
      @(posedge clk) toneValid <= 8'h00;
      idle(10);
    end
  endtask
  task automatic t_pcmTx(input logic b);
    int n;
    n = 0;
    while ((busAOe | busBOe) !== 1'b0 && n < 600) begin
      @(negedge clk);
      n++;
    end
    while ((b ? busBOe : busAOe) !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n < 600), 8'h01);
    for (int k = 0; k < 8; k++) begin
      chk(curSlot, 8'(5 + k));
      chk(b ? busBOut : busAOut, (k < 4) ? 8'hff : 8'h00);
      chk({7'h00, b ? busAOe : busBOe}, 8'h00);
      repeat (12) @(negedge clk);
    end
    chk({6'h00, busAOe, busBOe}, 8'h00);
  endtask
  task automatic t_listen(input logic [7:0] req);
    logic [8:0] sr;
    logic [7:0] e;
    wr(pcm_port_pkg::LISTEN_OFS, 8'h03);
    wr(5'(pcm_port_pkg::LISTEN_OFS + 7), 8'h0e);
    wr(pcm_port_pkg::BUSREQ_OFS, req);
    idle(450);
    rdChk(pcm_port_pkg::BUSACT_OFS, req);
    for (int k = 0; k < 8; k += 7) begin
      e = ((k == 0) ? 8'h03 : 8'h0e) ^ (req[k] ? 8'hc3 : 8'h3c);
      @(posedge codecSync);
      sr = 9'h000;
      repeat (9) begin
        @(negedge codecClk);
        sr = {sr[7:0], codecOut[k]};
      end
      chk((sr[7:0] === e) ? sr[7:0] : sr[8:1], e);
    end
  endtask

  initial begin
    idle(6);
    rst_n <= 1'b1;
    idle(1);
    t_ctrl();
    wr(pcm_port_pkg::BASE_OFS, 8'h05);
    @(posedge clk) run <= 1'b1;
    t_hook();
    t_tone();
    t_pcmTx(1'b0);
    wr(pcm_port_pkg::TXBUS_OFS, 8'h01);
    t_pcmTx(1'b1);
    t_listen(8'h00);
    t_listen(8'h81);
    complete_run();
  end

  initial begin
    #800_000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end
endmodule
